// ==== core/rsx_consts.svh ====
// rsx_consts.svh: opcodes, addresses, flag positions and reset values
// of the return/subtract execution slice; included by the package users.
// assumes one processor clock, one bus cycle per clock.
//
// Functional notes
// - return: bump stack pointer, then load upper program counter byte from it
// - bump stack pointer again, then load lower program counter byte from it
// - return is opcode 39, five reads: OP, OP+1, SP, SP+1, SP+2
// - opcode 10, two reads: accumulator A minus B into accumulator A
// - accumulator-to-accumulator subtract leaves accumulator B untouched
// - both subtracts: carry flag means borrow
// - both subtracts: negative flag copies result bit 7
// - both subtracts: zero flag set when the whole result is zero
// - A minus B: overflow on signed overflow from bits 7
// - A minus B: carry set when B exceeds A unsigned
// - with-borrow: accumulator minus memory minus old carry into accumulator
// - with-borrow: carry set when operand plus old carry exceeds accumulator
// - with-borrow opcodes: 82 92 B2 A2 18A2; C2 D2 F2 E2 18E2
// - with-borrow cycles 2/3/4/4/5, direct at 00dd, FFFF dummy before index
`ifndef RSX_CONSTS_SVH
`define RSX_CONSTS_SVH

// opcodes
`define RSX_OP_RET      8'h39
`define RSX_OP_SBA      8'h10
`define RSX_OP_PFX_Y    8'h18
`define RSX_OP_SBC_IMM  8'h82
`define RSX_OP_SBC_DIR  8'h92
`define RSX_OP_SBC_EXT  8'hb2
`define RSX_OP_SBC_IDX  8'ha2
`define RSX_OP_ACC_B    6
// bus addresses
`define RSX_DUMMY_ADDR  16'hffff
`define RSX_ZERO_PAGE   8'h00
// flag positions in the condition code register
`define RSX_FLG_C       0
`define RSX_FLG_V       1
`define RSX_FLG_Z       2
`define RSX_FLG_N       3
`define RSX_KEEP_HI     7
`define RSX_KEEP_LO     4
// reset values
`define RSX_PC_RST      16'h0000
`define RSX_SP_RST      16'h00ff
`define RSX_CCR_RST     8'hd0
`define RSX_ACC_RST     8'h00

`endif

// ==== core/rsx_pkg.sv ====
// rsx_pkg.sv: state and addressing-mode types of the execution slice.
// assumes rsx_consts.svh is included by the users.
package rsx_pkg;

	typedef enum logic [3:0] {
		ST_OP, ST_PFX, ST_INH, ST_ARG, ST_ARG2, ST_DUMMY, ST_MEM, ST_STK, ST_RH, ST_RL
	} rsx_state_type;

	typedef enum logic [2:0] {
		MD_NONE, MD_RET, MD_SBA, MD_IMM, MD_DIR, MD_EXT, MD_IDX
	} rsx_mode_type;

endpackage

// ==== core/rsx_exec.sv ====
// rsx_exec.sv: bus sequencing and arithmetic for subroutine return and
// the two subtracts of an 8-bit core.
// assumes memory answers rdData in the same cycle that busAddr is shown,
// and that all inputs come from logic on mclk.
`timescale 1ns/1ps
`include "rsx_consts.svh"

module rsx_exec
	import rsx_pkg::*;
(
	input  wire logic        mclk,
	input  wire logic        arst_n,
	input  wire logic [7:0]  rdData,
	input  wire logic [15:0] idxX,
	input  wire logic [15:0] idxY,
	input  wire logic        ldEn,
	input  wire logic [7:0]  ldAccA,
	input  wire logic [7:0]  ldAccB,
	input  wire logic [15:0] ldSp,
	input  wire logic [15:0] ldPc,
	input  wire logic [7:0]  ldCcr,
	output logic      [15:0] busAddr,
	output logic             busRw,
	output logic      [7:0]  accumulatorA,
	output logic      [7:0]  accumulatorB,
	output logic      [7:0]  conditionCodeRegister,
	output logic      [15:0] progCounter,
	output logic      [15:0] stackPtr,
	output logic             instrDone
);

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------

	// opcode to addressing mode; prefixed opcodes only allow indexed
	function automatic rsx_mode_type rsx_decode(input logic [7:0] op, input logic pfx);
		logic [7:0] base;
		base = op & 8'hbf;
		rsx_decode = MD_NONE;
		if (pfx) begin
			if (base == `RSX_OP_SBC_IDX)
				rsx_decode = MD_IDX;
		end else if (op == `RSX_OP_RET) begin
			rsx_decode = MD_RET;
		end else if (op == `RSX_OP_SBA) begin
			rsx_decode = MD_SBA;
		end else if (base == `RSX_OP_SBC_IMM) begin
			rsx_decode = MD_IMM;
		end else if (base == `RSX_OP_SBC_DIR) begin
			rsx_decode = MD_DIR;
		end else if (base == `RSX_OP_SBC_EXT) begin
			rsx_decode = MD_EXT;
		end else if (base == `RSX_OP_SBC_IDX) begin
			rsx_decode = MD_IDX;
		end
	endfunction

	// bit-7 borrow and overflow; returns {carry, overflow, result}
	function automatic logic [9:0] rsx_sub(input logic [7:0] a, input logic [7:0] m,
		input logic cin);
		logic [7:0] r;
		logic       c;
		logic       v;
		r = a - m - {7'h00, cin};
		c = (~a[7] & m[7]) | (m[7] & r[7]) | (r[7] & ~a[7]);
		v = (a[7] & ~m[7] & ~r[7]) | (~a[7] & m[7] & r[7]);
		rsx_sub = {c, v, r};
	endfunction

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------

	rsx_state_type state_r, state_nxt;
	rsx_mode_type  mode_r, mode_nxt;
	logic [7:0]    opc_r, opc_nxt;
	logic          useY_r, useY_nxt;
	logic [7:0]    tmp_r, tmp_nxt;
	logic [15:0]   ea_r, ea_nxt;
	logic [15:0]   pc_r, pc_nxt;
	logic [15:0]   sp_r, sp_nxt;
	logic [7:0]    accumulator_a_r, accumulator_a_nxt;
	logic [7:0]    accumulator_b_r, accumulator_b_nxt;
	logic [7:0]    ccr_r, ccr_nxt;
	logic [15:0]   addr_r, addr_nxt;
	logic          rw_r, rw_nxt;
	logic          done_r, done_nxt;

	logic          isSba;
	logic          selB;
	logic          exec;
	logic [7:0]    minu;
	logic [7:0]    subt;
	logic          cin;
	logic [9:0]    subOut;

	// ----------------------------------------------------------------
	// arithmetic operand selection
	// ----------------------------------------------------------------

	// the subtract datapath is shared; inherent form forces cin low
	always_comb begin
		isSba  = (mode_r == MD_SBA);
		selB   = opc_r[`RSX_OP_ACC_B] && !isSba;
		exec   = (state_r == ST_INH && isSba) || (state_r == ST_ARG && mode_r == MD_IMM)
			|| (state_r == ST_MEM);
		minu   = selB ? accumulator_b_r : accumulator_a_r;
		subt   = isSba ? accumulator_b_r : rdData;
		cin    = isSba ? 1'b0 : ccr_r[`RSX_FLG_C];
		subOut = rsx_sub(minu, subt, cin);
	end

	// ----------------------------------------------------------------
	// sequencer
	// ----------------------------------------------------------------

	// one state per bus cycle; the address of the next cycle follows state_nxt
	always_comb begin
		state_nxt = state_r;
		mode_nxt  = mode_r;
		opc_nxt   = opc_r;
		useY_nxt  = useY_r;
		tmp_nxt   = tmp_r;
		ea_nxt    = ea_r;
		pc_nxt    = pc_r;
		sp_nxt    = sp_r;
		accumulator_a_nxt  = accumulator_a_r;
		accumulator_b_nxt  = accumulator_b_r;
		ccr_nxt   = ccr_r;
		done_nxt  = 1'b0;
		rw_nxt    = 1'b1;
		case (state_r)
			ST_OP: begin
				pc_nxt  = pc_r + 16'h0001;
				opc_nxt = rdData;
				if (rdData == `RSX_OP_PFX_Y) begin
					useY_nxt  = 1'b1;
					state_nxt = ST_PFX;
				end else begin
					useY_nxt  = 1'b0;
					mode_nxt  = rsx_decode(rdData, 1'b0);
					if (mode_nxt == MD_RET || mode_nxt == MD_SBA || mode_nxt == MD_NONE)
						state_nxt = ST_INH;
					else
						state_nxt = ST_ARG;
				end
			end
			ST_PFX: begin
				pc_nxt    = pc_r + 16'h0001;
				opc_nxt   = rdData;
				mode_nxt  = rsx_decode(rdData, 1'b1);
				// unknown prefixed opcodes are dropped
				state_nxt = (mode_nxt == MD_IDX) ? ST_ARG : ST_OP;
			end
			ST_INH: begin
				// dummy read at OP+1; the program counter does not move
				if (mode_r == MD_RET)
					state_nxt = ST_STK;
				else
					state_nxt = ST_OP;
				if (isSba)
					done_nxt = 1'b1;
			end
			ST_ARG: begin
				pc_nxt  = pc_r + 16'h0001;
				tmp_nxt = rdData;
				case (mode_r)
					MD_IMM: begin
						state_nxt = ST_OP;
						done_nxt  = 1'b1;
					end
					MD_DIR: begin
						ea_nxt    = {`RSX_ZERO_PAGE, rdData};
						state_nxt = ST_MEM;
					end
					MD_EXT:  state_nxt = ST_ARG2;
					default: state_nxt = ST_DUMMY;
				endcase
			end
			ST_ARG2: begin
				pc_nxt    = pc_r + 16'h0001;
				ea_nxt    = {tmp_r, rdData};
				state_nxt = ST_MEM;
			end
			ST_DUMMY: begin
				// index sum formed during the dummy cycle
				ea_nxt    = (useY_r ? idxY : idxX) + {8'h00, tmp_r};
				state_nxt = ST_MEM;
			end
			ST_MEM: begin
				state_nxt = ST_OP;
				done_nxt  = 1'b1;
			end
			ST_STK: begin
				sp_nxt    = sp_r + 16'h0001;
				state_nxt = ST_RH;
			end
			ST_RH: begin
				tmp_nxt   = rdData;
				sp_nxt    = sp_r + 16'h0001;
				state_nxt = ST_RL;
			end
			ST_RL: begin
				pc_nxt    = {tmp_r, rdData};
				state_nxt = ST_OP;
				done_nxt  = 1'b1;
			end
			default: state_nxt = ST_OP;
		endcase

		// upper flags are never written, return never reaches here
		if (exec) begin
			if (selB)
				accumulator_b_nxt = subOut[7:0];
			else
				accumulator_a_nxt = subOut[7:0];
			// borrow into carry, from the result
			ccr_nxt[`RSX_FLG_C] = subOut[9];
			ccr_nxt[`RSX_FLG_V] = subOut[8];
			ccr_nxt[`RSX_FLG_N] = subOut[7];
			ccr_nxt[`RSX_FLG_Z] = (subOut[7:0] == 8'h00);
		end

		// preload restarts the sequencer at a fresh opcode fetch
		if (ldEn) begin
			state_nxt = ST_OP;
			pc_nxt    = ldPc;
			sp_nxt    = ldSp;
			accumulator_a_nxt  = ldAccA;
			accumulator_b_nxt  = ldAccB;
			ccr_nxt   = ldCcr;
			done_nxt  = 1'b0;
		end

		// addresses per cycle, dummy at FFFF
		case (state_nxt)
			ST_DUMMY:              addr_nxt = `RSX_DUMMY_ADDR;
			ST_MEM:                addr_nxt = ea_nxt;
			ST_STK, ST_RH, ST_RL:  addr_nxt = sp_nxt;
			default:               addr_nxt = pc_nxt;
		endcase
	end

	// register stage only
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			state_r <= ST_OP;
			mode_r  <= MD_NONE;
			opc_r   <= 8'h00;
			useY_r  <= 1'b0;
			tmp_r   <= 8'h00;
			ea_r    <= 16'h0000;
			pc_r    <= `RSX_PC_RST;
			sp_r    <= `RSX_SP_RST;
			accumulator_a_r  <= `RSX_ACC_RST;
			accumulator_b_r  <= `RSX_ACC_RST;
			ccr_r   <= `RSX_CCR_RST;
			addr_r  <= `RSX_PC_RST;
			rw_r    <= 1'b1;
			done_r  <= 1'b0;
		end else begin
			state_r <= state_nxt;
			mode_r  <= mode_nxt;
			opc_r   <= opc_nxt;
			useY_r  <= useY_nxt;
			tmp_r   <= tmp_nxt;
			ea_r    <= ea_nxt;
			pc_r    <= pc_nxt;
			sp_r    <= sp_nxt;
			accumulator_a_r  <= accumulator_a_nxt;
			accumulator_b_r  <= accumulator_b_nxt;
			ccr_r   <= ccr_nxt;
			addr_r  <= addr_nxt;
			rw_r    <= rw_nxt;
			done_r  <= done_nxt;
		end
	end

	// outputs straight from flops
	assign busAddr               = addr_r;
	assign busRw                 = rw_r;
	assign accumulatorA          = accumulator_a_r;
	assign accumulatorB          = accumulator_b_r;
	assign conditionCodeRegister = ccr_r;
	assign progCounter           = pc_r;
	assign stackPtr              = sp_r;
	assign instrDone             = done_r;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------

	default clocking cb @(posedge mclk); endclocking
	default disable iff (!arst_n || ldEn);
	property p_ret_high;
		state_r == ST_RH |-> busAddr == stackPtr && busAddr == $past(busAddr) + 16'h0001;
	endproperty
	a_ret_high: assert property (p_ret_high) else $error("high byte address wrong");

	property p_ret_pc;
		state_r == ST_RL ##1 instrDone |-> progCounter == {$past(rdData, 2), $past(rdData)}
			&& stackPtr == $past(stackPtr, 3) + 16'h0002;
	endproperty
	a_ret_pc: assert property (p_ret_pc) else $error("return address wrong");

	property p_ret_seq;
		state_r == ST_OP && rdData == 8'h39 |=> state_r == ST_INH ##1 state_r == ST_STK
			##1 state_r == ST_RH ##1 state_r == ST_RL ##1 state_r == ST_OP;
	endproperty
	a_ret_seq: assert property (p_ret_seq) else $error("return cycles wrong");

	property p_sba;
		state_r == ST_INH && mode_r == MD_SBA |=> instrDone && accumulatorB == $past(accumulator_b_r)
			&& accumulatorA == $past(accumulator_a_r) - $past(accumulator_b_r);
	endproperty
	a_sba: assert property (p_sba) else $error("A minus B wrong");
	property p_sba_flags;
		state_r == ST_INH && mode_r == MD_SBA |=> conditionCodeRegister[0]
			== ($past(accumulator_b_r) > $past(accumulator_a_r)) && conditionCodeRegister[1]
			== ($past(accumulator_a_r[7]) != $past(accumulator_b_r[7]) && accumulatorA[7] != $past(accumulator_a_r[7]));
	endproperty
	a_sba_flags: assert property (p_sba_flags) else $error("A minus B flags wrong");

	property p_nz;
		instrDone && mode_r != MD_RET |-> conditionCodeRegister[3] == (selB ? accumulator_b_r[7]
			: accumulator_a_r[7]) && conditionCodeRegister[2] == ((selB ? accumulator_b_r : accumulator_a_r) == 8'h00);
	endproperty
	a_nz: assert property (p_nz) else $error("N or Z wrong");

	property p_sbc;
		state_r == ST_MEM && !selB |=> accumulatorA
			== $past(accumulator_a_r) - $past(rdData) - 8'($past(ccr_r[0]))
			&& conditionCodeRegister[0] == ({1'b0, $past(rdData)} + 9'($past(ccr_r[0]))
			> {1'b0, $past(accumulator_a_r)});
	endproperty
	a_sbc: assert property (p_sbc) else $error("with-borrow result wrong");
	property p_sbc_v;
		state_r == ST_MEM && selB |=> conditionCodeRegister[1] == ($past(accumulator_b_r[7])
			!= $past(rdData[7]) && accumulatorB[7] != $past(accumulator_b_r[7]));
	endproperty
	a_sbc_v: assert property (p_sbc_v) else $error("with-borrow overflow wrong");

	property p_idx;
		state_r == ST_DUMMY |-> busAddr == 16'hffff ##1 busAddr == (useY_r ? idxY : idxX)
			+ {8'h00, tmp_r};
	endproperty
	a_idx: assert property (p_idx) else $error("indexed addressing wrong");

	property p_dec;
		state_r == ST_OP && rdData == 8'hd2 |=> state_r == ST_ARG ##1 state_r == ST_MEM
			&& busAddr[15:8] == 8'h00 ##1 instrDone;
	endproperty
	a_dec: assert property (p_dec) else $error("direct decode wrong");

	property p_keep;
		instrDone |-> conditionCodeRegister[7:4] == $past(ccr_r[7:4])
			&& (mode_r != MD_RET || conditionCodeRegister == $past(ccr_r));
	endproperty
	a_keep: assert property (p_keep) else $error("protected flags changed");

	c_ret: cover property (state_r == ST_RL ##1 instrDone);
	c_sba: cover property (state_r == ST_INH && isSba ##1 conditionCodeRegister[0]);
	c_idxy: cover property (state_r == ST_DUMMY && useY_r);
	c_ext: cover property (state_r == ST_ARG2 ##1 state_r == ST_MEM);

endmodule

// ==== test/rsx_mem_model.sv ====
// rsx_mem_model.sv: byte memory answering the core's bus in the same cycle.
// assumes the bench fills mem by hierarchical write before each instruction.
`timescale 1ns/1ps

module rsx_mem_model (
	input  wire logic [15:0] busAddr,
	input  wire logic        busRw,
	output logic      [7:0]  rdData
);
	logic [7:0] mem [0:65535];

	// scrambled start image; an unloaded byte reads as zero only where its two address bytes XOR to 5a
	initial begin
		for (int i = 0; i < 65536; i++) begin
			mem[i] = i[7:0] ^ i[15:8] ^ 8'h5a;
		end
	end

	// no write cycle is legal here, so one shows inverted data and gets caught
	assign rdData = busRw ? mem[busAddr] : ~mem[busAddr];
endmodule

// ==== test/tb.sv ====
// tb.sv: self-checking bench for the return and subtract execution slice.
// assumes rsx_mem_model answers reads combinationally on the same clock.
`timescale 1ns/1ps
`include "rsx_consts.svh"

module tb;
	import rsx_pkg::*;
	logic        mclk, arst_n, ldEn, busRw, instrDone;
	logic [7:0]  rdData, ldAccA, ldAccB, ldCcr;
	logic [7:0]  accumulatorA, accumulatorB, conditionCodeRegister;
	logic [15:0] idxX, idxY, ldSp, ldPc, busAddr, progCounter, stackPtr;
	logic [15:0] lfsrState = 16'h002a;
	int          err_total = 0;
	int          samples_checked = 0;
	logic [7:0]  ops [12] = '{8'h39, 8'h10, 8'h82, 8'h92, 8'hb2, 8'ha2, 8'ha2,
		8'hc2, 8'hd2, 8'hf2, 8'he2, 8'he2};

	rsx_exec dut_u (.mclk(mclk), .arst_n(arst_n), .rdData(rdData), .idxX(idxX),
		.idxY(idxY), .ldEn(ldEn), .ldAccA(ldAccA), .ldAccB(ldAccB), .ldSp(ldSp),
		.ldPc(ldPc), .ldCcr(ldCcr), .busAddr(busAddr), .busRw(busRw),
		.accumulatorA(accumulatorA), .accumulatorB(accumulatorB),
		.conditionCodeRegister(conditionCodeRegister), .progCounter(progCounter),
		.stackPtr(stackPtr), .instrDone(instrDone));
	rsx_mem_model mem_u (.busAddr(busAddr), .busRw(busRw), .rdData(rdData));

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function automatic logic [7:0] rnd8();
		lfsrState = {lfsrState[14:0], lfsrState[15] ^ lfsrState[13] ^ lfsrState[12] ^ lfsrState[10]};
		return lfsrState[7:0];
	endfunction

	task automatic check(input logic [15:0] seen, input logic [15:0] expv);
		samples_checked++;
		if (seen !== expv) begin
			err_total++;
			$display("[ERR] t=%0t seen=%h expected=%h", $time, seen, expv);
		end
	endtask

	task automatic tally_and_finish();
		$display("comparisons %0d mismatches %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	task automatic reset_vals();
		check(busAddr, 16'h0000);
		check(stackPtr, `RSX_SP_RST);
		check({conditionCodeRegister, accumulatorA}, {`RSX_CCR_RST, `RSX_ACC_RST});
		check({instrDone, busRw}, 2'b01);
	endtask

	// ----------------------------------------
	// one instruction from preload to next fetch
	// ----------------------------------------
	// the bench memory image is the only source of expected operand bytes, bar accumulator B for A minus B
	task automatic exec(input logic [7:0] op, input logic pfx);
		logic [15:0] p, s, ea, nxt, q[$];
		logic [7:0]  a, b, c, m, sel, r, xa, xb, xc;
		logic        cin, v;
		p = {8'h10, rnd8()};
		s = {8'h20, rnd8()};
		a = rnd8();
		b = rnd8();
		c = rnd8();
		idxX = {rnd8(), rnd8()};
		idxY = {rnd8(), rnd8()};
		for (int i = 1; i < 4; i++) mem_u.mem[p + i] = rnd8();
		mem_u.mem[s + 16'h1] = rnd8();
		mem_u.mem[s + 16'h2] = rnd8();
		mem_u.mem[p] = pfx ? 8'h18 : op;
		if (pfx) mem_u.mem[p + 16'h1] = op;
		q = {p, p + 16'h1};
		ea = p + 16'h1;
		nxt = p + 16'h2;
		if (op == 8'h39) begin
			q = {q, s, s + 16'h1, s + 16'h2};
			nxt = {mem_u.mem[s + 16'h1], mem_u.mem[s + 16'h2]};
		end else if (op == 8'h10) begin
			nxt = p + 16'h1;
		end else if (pfx) begin
			ea = idxY + {8'h00, mem_u.mem[p + 16'h2]};
			q = {q, p + 16'h2, 16'hffff, ea};
			nxt = p + 16'h3;
		end else if (op[5:4] == 2'b01) begin
			ea = {8'h00, mem_u.mem[p + 16'h1]};
			q = {q, ea};
		end else if (op[5:4] == 2'b11) begin
			ea = {mem_u.mem[p + 16'h1], mem_u.mem[p + 16'h2]};
			q = {q, p + 16'h2, ea};
			nxt = p + 16'h3;
		end else if (op[5:4] == 2'b10) begin
			ea = idxX + {8'h00, mem_u.mem[p + 16'h1]};
			q = {q, 16'hffff, ea};
		end
		// keep the operand off the program bytes so the walk stays as built
		if (ea - p > 16'h3) mem_u.mem[ea] = rnd8();
		m = mem_u.mem[ea];
		sel = op[6] ? b : a;
		cin = c[0];
		if (op == 8'h10) begin
			m = b;
			cin = 1'b0;
		end
		r = sel - m - {7'h00, cin};
		v = (sel[7] & ~m[7] & ~r[7]) | (~sel[7] & m[7] & r[7]);
		xa = (op[6] || op == 8'h39) ? a : r;
		xb = op[6] ? r : b;
		xc = {c[7:4], r[7], r == 8'h00, v, (int'(m) + int'(cin)) > int'(sel)};
		if (op == 8'h39) xc = c;
		ldPc = p;
		ldSp = s;
		ldAccA = a;
		ldAccB = b;
		ldCcr = c;
		ldEn = 1'b1;
		@(negedge mclk);
		ldEn = 1'b0;
		foreach (q[k]) begin
			check(busAddr, q[k]);
			check({instrDone, busRw}, 2'b01);
			@(negedge mclk);
		end
		check(busAddr, nxt);
		check(instrDone, 1'b1);
		check(accumulatorA, xa);
		check(accumulatorB, xb);
		check(conditionCodeRegister[3:0], xc[3:0]);
		check(conditionCodeRegister[7:4], xc[7:4]);
		check(stackPtr, op == 8'h39 ? s + 16'h2 : s);
		if (op == 8'h39) check(progCounter, nxt);
		// idle edge with preload low, so the core's done-cycle assertions are not disabled
		@(negedge mclk);
	endtask

	// ----------------------------------------
	// clock, watchdog, main sequence
	// ----------------------------------------
	initial begin
		mclk = 1'b0;
		forever #2.5 mclk = ~mclk;
	end

	// under six cycles an instruction; this span is nearly fifteen times the run
	initial begin
		#100000;
		err_total++;
		$display("watchdog expired");
		tally_and_finish();
	end

	initial begin
		{arst_n, ldEn, ldAccA, ldAccB, ldCcr} = '0;
		{idxX, idxY, ldSp, ldPc} = '0;
		repeat (8) @(posedge mclk);
		@(negedge mclk);
		reset_vals();
		arst_n = 1'b1;
		repeat (2) @(negedge mclk);
		// every opcode, both accumulators, both index paths
		for (int n = 0; n < 20; n++) begin
			for (int k = 0; k < 12; k++) exec(ops[k], k == 6 || k == 11);
		end
		$display("instruction sweep done");
		// reset dropped while the core is running
		@(negedge mclk);
		arst_n = 1'b0;
		@(negedge mclk);
		reset_vals();
		arst_n = 1'b1;
		@(negedge mclk);
		exec(8'he2, 1'b1);
		$display("mid-run reset done");
		tally_and_finish();
	end
endmodule
